//--- inc/sensor_fifo_defs.vh
// constants of the sensor sample fifo: register offsets, field positions,
// reset values and sizes; included by the design files, no logic here
//
// Behaviour
// - buffer holds 4096 sixteen-bit sample words
// - pacing from combo ready, hub ready, step
// - per-set decimation by 2,3,4,8,16,32
// - eleven-bit watermark split over two registers
// - three-bit mode field picks five modes
// - bypass stores nothing and empties buffer
// - mode 001 stores until full, then stops
// - halt bit limits depth to watermark
// - mode 110 overwrites oldest when full
// - watermark flag when unread count reaches watermark
// - watermark flag routable to either irq pin
// - full flag routable to irq pin a
// - overwrite of oldest sample sets overrun flag
// - thirteen-bit unread count across three status registers
// - mode 011: stop-mode on trigger, else continuous
// - mode 100: continuous on trigger, else bypass
// - sample read out as low and high byte
// - four status registers show flags and count
// - four six-byte sets in fixed order
// - registers reachable over serial host interface
`ifndef SENSOR_FIFO_DEFS_VH
`define SENSOR_FIFO_DEFS_VH

// register offsets
`define REG_THRESH_LOW      8'h06
`define REG_THRESH_HIGH_CFG 8'h07
`define REG_DECIM_A         8'h08
`define REG_DECIM_B         8'h09
`define REG_MODE_SELECT     8'h0a
`define REG_IRQ_A_ROUTE     8'h0d
`define REG_IRQ_B_ROUTE     8'h0e
`define REG_STATE_A         8'h3a
`define REG_STATE_B         8'h3b
`define REG_STATE_C         8'h3c
`define REG_STATE_D         8'h3d
`define REG_READ_LOW        8'h3e
`define REG_READ_HIGH       8'h3f

// reset value of every writable register
`define CFG_RESET           8'h00

// field positions
`define POS_PACE_SEL        3
`define POS_HALT_WM         6
`define POS_TRIG_SEL        3
`define POS_SET4_SEL        5
`define POS_IRQ_WM          3
`define POS_IRQ_FULL        5

// mode codes
`define MODE_BYPASS         3'h0
`define MODE_STOP_FULL      3'h1
`define MODE_CONT_TO_STOP   3'h3
`define MODE_BYPASS_TO_CONT 3'h4
`define MODE_CONTINUOUS     3'h6

// sizes
`define FIFO_DEPTH          13'h1000
`define ADDR_W              12
`define WORD_W              16
`define SET_BITS            48
`define WORDS_PER_SET       2'h2

`endif

//--- rtl/sample_ram.v
// 4096 x 16 sample store with a registered read port
// assumes one write and one read address per clock, same clock domain
`timescale 1ns/100ps
`include "sensor_fifo_defs.vh"

module sample_ram
(
  // clock
  input  wire                 core_clk,
  // write side
  input  wire                 wrEn,
  input  wire [`ADDR_W-1:0]   wrAddr,
  input  wire [`WORD_W-1:0]   wrData,
  // read side
  input  wire [`ADDR_W-1:0]   rdAddr,
  output reg  [`WORD_W-1:0]   rdData_ff
);

  reg [`WORD_W-1:0] mem [0:4095];

  // no reset on the array, so it maps onto block ram
  always @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData_ff <= mem[rdAddr];
  end

endmodule // sample_ram

//--- rtl/sensor_sample_fifo.v
// sample fifo batching motion sensor data sets for the host
// assumes all inputs synchronous to core_clk; the serial host interface
// decodes frames into the byte-wide register port below
`timescale 1ns/100ps
`include "sensor_fifo_defs.vh"

module sensor_sample_fifo
(
  // clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // register port from the serial host interface
  input  wire [7:0]   regAddr,
  input  wire         regWrite,
  input  wire [7:0]   regWData,
  input  wire         regRead,
  output reg  [7:0]   regRData_ff,
  // pacing pulses
  input  wire         comboDataReady,
  input  wire         hubDataReady,
  input  wire         stepDetect,
  // trigger bits from the event sources
  input  wire         functionEvent,
  input  wire         tapEvent,
  input  wire         wakeupEvent,
  input  wire         orientationEvent,
  // data sets, three words each, and the one-word temperature
  input  wire [47:0]  gyroSet,
  input  wire [47:0]  accelSet,
  input  wire [47:0]  extSensorFirstSet,
  input  wire [47:0]  extSensorLastSet,
  input  wire [47:0]  stepTimeSet,
  input  wire [15:0]  temperature,
  // interrupt pins
  output reg          irqPinA_ff,
  output reg          irqPinB_ff
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EMIT = 2'b10;

  // decimation code to factor minus one; code 0 means set not stored
  function [4:0] decimMinusOne;
    input [2:0] code;
    begin
      case (code)
        3'h2:    decimMinusOne = 5'h01;
        3'h3:    decimMinusOne = 5'h02;
        3'h4:    decimMinusOne = 5'h03;
        3'h5:    decimMinusOne = 5'h07;
        3'h6:    decimMinusOne = 5'h0f;
        3'h7:    decimMinusOne = 5'h1f;
        default: decimMinusOne = 5'h00;
      endcase
    end
  endfunction

  // configuration registers
  reg  [7:0]          threshLow_ff;
  reg  [7:0]          threshHigh_ff;
  reg  [7:0]          decimA_ff;
  reg  [7:0]          decimB_ff;
  reg  [7:0]          modeSel_ff;
  reg  [7:0]          irqARoute_ff;
  reg  [7:0]          irqBRoute_ff;
  // fifo state
  reg  [`ADDR_W-1:0]  wrPtr_ff;
  reg  [`ADDR_W-1:0]  rdPtr_ff;
  reg  [12:0]         count_ff;
  reg                 overrun_ff;
  reg  [1:0]          state_ff;
  reg  [1:0]          setIdx_ff;
  reg  [1:0]          wordIdx_ff;
  reg  [3:0]          storeMask_ff;
  reg  [191:0]        snap_ff;
  reg  [4:0]          decimCnt_ff [0:3];
  // combinational, except headWord from the ram's registered read port
  reg                 paceEvent;
  reg                 trigBit;
  reg  [47:0]         fourthSet;
  reg                 bypassNow;
  reg                 stopWhenFull;
  wire [`WORD_W-1:0]  headWord;
  wire [10:0]         watermarkLevel;
  wire                haltAtWatermark;
  wire [12:0]         capacity;
  wire                fullNow;
  wire                emptyNow;
  wire                watermarkFlag;
  wire                emitWrite;
  wire                popNow;
  wire                discardOldest;
  wire [7:0]          bitBase;
  wire [2:0]          decimCode [0:3];
  wire [3:0]          decimHit;

  assign watermarkLevel  = {threshHigh_ff[2:0], threshLow_ff};
  assign haltAtWatermark = decimB_ff[`POS_HALT_WM];
  // depth shrinks to the watermark when halting there
  assign capacity = haltAtWatermark ? {2'h0, watermarkLevel} : `FIFO_DEPTH;
  assign fullNow  = (count_ff >= capacity);
  assign emptyNow = (count_ff == 13'h0000);
  assign watermarkFlag = (count_ff >= {2'h0, watermarkLevel});

  // pacing source select
  always @*
  begin
    case (threshHigh_ff[`POS_PACE_SEL+1:`POS_PACE_SEL])
      2'h0:    paceEvent = comboDataReady;
      2'h1:    paceEvent = hubDataReady;
      2'h2:    paceEvent = stepDetect;
      default: paceEvent = 1'b0;
    endcase
  end

  // trigger bit select for the two switching modes
  always @*
  begin
    case (modeSel_ff[`POS_TRIG_SEL+1:`POS_TRIG_SEL])
      2'h0:    trigBit = functionEvent;
      2'h1:    trigBit = tapEvent;
      2'h2:    trigBit = wakeupEvent;
      default: trigBit = orientationEvent;
    endcase
  end

  // effective behaviour from mode code and trigger; unknown codes act as bypass
  always @*
  begin
    bypassNow    = 1'b0;
    stopWhenFull = 1'b0;
    case (modeSel_ff[2:0])
      `MODE_BYPASS:         bypassNow = 1'b1;
      `MODE_STOP_FULL:      stopWhenFull = 1'b1;
      `MODE_CONT_TO_STOP:   stopWhenFull = trigBit;
      `MODE_BYPASS_TO_CONT: bypassNow = ~trigBit;
      `MODE_CONTINUOUS:     stopWhenFull = 1'b0;
      default:              bypassNow = 1'b1;
    endcase
  end

  // fourth set content: ext sensor tail, step/time or temperature
  always @*
  begin
    case (modeSel_ff[`POS_SET4_SEL+1:`POS_SET4_SEL])
      2'h1:    fourthSet = stepTimeSet;
      2'h2:    fourthSet = {32'h00000000, temperature};
      default: fourthSet = extSensorLastSet;
    endcase
  end

  // decimation codes: two per register, one per set
  assign decimCode[0] = decimA_ff[2:0];
  assign decimCode[1] = decimA_ff[5:3];
  assign decimCode[2] = decimB_ff[2:0];
  assign decimCode[3] = decimB_ff[5:3];

  // one decimation counter per data set
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_decim
      assign decimHit[gi] = (decimCode[gi] != 3'h0) &&
                            (decimCnt_ff[gi] >= decimMinusOne(decimCode[gi]));
      always @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          decimCnt_ff[gi] <= 5'h00;
        end
        else if (bypassNow)
        begin
          decimCnt_ff[gi] <= 5'h00;
        end
        else if (paceEvent && (state_ff == ST_IDLE))
        begin
          decimCnt_ff[gi] <= decimHit[gi] ? 5'h00 : decimCnt_ff[gi] + 5'h01;
        end
      end
    end
  endgenerate

  // bit offset of the current word inside the snapshot: set*48 + word*16
  assign bitBase = {1'b0, setIdx_ff, 5'h00} + {2'h0, setIdx_ff, 4'h0} +
                   {2'h0, wordIdx_ff, 4'h0};
  assign emitWrite = (state_ff == ST_EMIT) && storeMask_ff[setIdx_ff] && !bypassNow;

  // host pops only on the high byte, so a low/high pair stays coherent
  assign popNow = regRead && (regAddr == `REG_READ_HIGH) && !emptyNow;
  // in stop-when-full a write into a full buffer is dropped instead
  assign discardOldest = emitWrite && fullNow && !stopWhenFull && !popNow;

  // emitter: snapshot all sets on a pace event, then write word by word
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff     <= ST_IDLE;
      setIdx_ff    <= 2'h0;
      wordIdx_ff   <= 2'h0;
      storeMask_ff <= 4'h0;
      snap_ff      <= 192'h0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          // pace events arriving mid-emit are dropped; rates are far apart
          if (paceEvent && !bypassNow && (decimHit != 4'h0))
          begin
            state_ff     <= ST_EMIT;
            storeMask_ff <= decimHit;
            setIdx_ff    <= 2'h0;
            wordIdx_ff   <= 2'h0;
            snap_ff      <= {fourthSet, extSensorFirstSet, accelSet, gyroSet};
          end
        end
        ST_EMIT:
        begin
          if (bypassNow)
          begin
            state_ff <= ST_IDLE;
          end
          else if (wordIdx_ff == `WORDS_PER_SET)
          begin
            wordIdx_ff <= 2'h0;
            setIdx_ff  <= setIdx_ff + 2'h1;
            if (setIdx_ff == 2'h3)
            begin
              state_ff <= ST_IDLE;
            end
          end
          else
          begin
            wordIdx_ff <= wordIdx_ff + 2'h1;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // pointers, count and overrun
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_ff   <= {`ADDR_W{1'b0}};
      rdPtr_ff   <= {`ADDR_W{1'b0}};
      count_ff   <= 13'h0000;
      overrun_ff <= 1'b0;
    end
    else if (bypassNow)
    begin
      // bypass keeps the buffer empty
      wrPtr_ff   <= {`ADDR_W{1'b0}};
      rdPtr_ff   <= {`ADDR_W{1'b0}};
      count_ff   <= 13'h0000;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (emitWrite && (!fullNow || !stopWhenFull || popNow))
      begin
        wrPtr_ff <= wrPtr_ff + 12'h001;
      end
      if (popNow || discardOldest)
      begin
        rdPtr_ff <= rdPtr_ff + 12'h001;
      end
      if (emitWrite && !fullNow && !popNow)
      begin
        count_ff <= count_ff + 13'h0001;
      end
      else if (popNow && !emitWrite)
      begin
        count_ff <= count_ff - 13'h0001;
      end
      // a pop in the same cycle blocks the overwrite, so the pop clears the flag
      if (discardOldest)
      begin
        overrun_ff <= 1'b1;
      end
      else if (popNow)
      begin
        overrun_ff <= 1'b0;
      end
    end
  end

  sample_ram u_ram
  (
    .core_clk  (core_clk),
    .wrEn      (emitWrite && (!fullNow || !stopWhenFull || popNow)),
    .wrAddr    (wrPtr_ff),
    .wrData    (snap_ff[bitBase +: `WORD_W]),
    .rdAddr    (rdPtr_ff),
    .rdData_ff (headWord)
  );

  // configuration register writes
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      threshLow_ff  <= `CFG_RESET;
      threshHigh_ff <= `CFG_RESET;
      decimA_ff     <= `CFG_RESET;
      decimB_ff     <= `CFG_RESET;
      modeSel_ff    <= `CFG_RESET;
      irqARoute_ff  <= `CFG_RESET;
      irqBRoute_ff  <= `CFG_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `REG_THRESH_LOW:      threshLow_ff  <= regWData;
        `REG_THRESH_HIGH_CFG: threshHigh_ff <= regWData;
        `REG_DECIM_A:         decimA_ff     <= regWData;
        `REG_DECIM_B:         decimB_ff     <= regWData;
        `REG_MODE_SELECT:     modeSel_ff    <= regWData;
        `REG_IRQ_A_ROUTE:     irqARoute_ff  <= regWData;
        `REG_IRQ_B_ROUTE:     irqBRoute_ff  <= regWData;
        default:              threshLow_ff  <= threshLow_ff;
      endcase
    end
  end

  // register reads; unmapped offsets answer zero
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      regRData_ff <= 8'h00;
    end
    else if (regRead)
    begin
      case (regAddr)
        `REG_THRESH_LOW:      regRData_ff <= threshLow_ff;
        `REG_THRESH_HIGH_CFG: regRData_ff <= threshHigh_ff;
        `REG_DECIM_A:         regRData_ff <= decimA_ff;
        `REG_DECIM_B:         regRData_ff <= decimB_ff;
        `REG_MODE_SELECT:     regRData_ff <= modeSel_ff;
        `REG_IRQ_A_ROUTE:     regRData_ff <= irqARoute_ff;
        `REG_IRQ_B_ROUTE:     regRData_ff <= irqBRoute_ff;
        `REG_STATE_A:         regRData_ff <= count_ff[7:0];
        `REG_STATE_B:         regRData_ff <= {watermarkFlag, overrun_ff, fullNow,
                                              emptyNow, 1'b0, count_ff[10:8]};
        `REG_STATE_C:         regRData_ff <= {count_ff[12:11], 2'h0, storeMask_ff};
        `REG_STATE_D:         regRData_ff <= {4'h0, setIdx_ff, wordIdx_ff};
        `REG_READ_LOW:        regRData_ff <= emptyNow ? 8'h00 : headWord[7:0];
        `REG_READ_HIGH:       regRData_ff <= emptyNow ? 8'h00 : headWord[15:8];
        default:              regRData_ff <= 8'h00;
      endcase
    end
  end

  // interrupt routing, registered so the pins never glitch
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irqPinA_ff <= 1'b0;
      irqPinB_ff <= 1'b0;
    end
    else
    begin
      irqPinA_ff <= (watermarkFlag & irqARoute_ff[`POS_IRQ_WM]) |
                    (fullNow & irqARoute_ff[`POS_IRQ_FULL]);
      irqPinB_ff <= watermarkFlag & irqBRoute_ff[`POS_IRQ_WM];
    end
  end

endmodule // sensor_sample_fifo

//--- testbench/sensor_fifo_checker.sv
// checker for the sample fifo register port and interrupt pins
// assumes it is bound to sensor_sample_fifo and sees only its ports
`timescale 1ns/100ps
module sensor_fifo_checker
(
  // clock and reset
  input wire       core_clk,
  input wire       rst,
  // register port
  input wire [7:0] regAddr,
  input wire       regWrite,
  input wire [7:0] regWData,
  input wire       regRead,
  input wire [7:0] regRData_ff,
  // interrupt pins
  input wire       irqPinA_ff,
  input wire       irqPinB_ff
);
  reg [7:0] wmLow_ff;
  reg [7:0] wmHigh_ff;
  reg [7:0] mode_ff;
  reg [7:0] routeA_ff;
  reg [7:0] routeB_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // shadows of the writable registers the checks lean on
  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      wmLow_ff  <= 8'h00;
      wmHigh_ff <= 8'h00;
      mode_ff   <= 8'h00;
      routeA_ff <= 8'h00;
      routeB_ff <= 8'h00;
    end
    else if (regWrite)
    begin
      if (regAddr == 8'h06) wmLow_ff <= regWData;
      if (regAddr == 8'h07) wmHigh_ff <= regWData;
      if (regAddr == 8'h0a) mode_ff <= regWData;
      if (regAddr == 8'h0d) routeA_ff <= regWData;
      if (regAddr == 8'h0e) routeB_ff <= regWData;
    end

  property p_rdata_hold;
    !regRead |=> $stable(regRData_ff);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_unmapped;
    regRead && !(regAddr inside {[8'h06:8'h0a], 8'h0d, 8'h0e, [8'h3a:8'h3f]})
      |=> regRData_ff == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped offset read nonzero");
  property p_cfg_back;
    regRead && regAddr == 8'h06 |=> regRData_ff == wmLow_ff;
  endproperty
  a_cfg_back: assert property (p_cfg_back)
    else $error("watermark low byte readback wrong");
  property p_empty;
    regRead && regAddr == 8'h3b
      |=> !regRData_ff[4] || (regRData_ff[2:0] == 3'h0 && !regRData_ff[5]);
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty flag with nonzero count");
  property p_wm_zero;
    regRead && regAddr == 8'h3b && wmLow_ff == 8'h00 && wmHigh_ff[2:0] == 3'h0
      && $stable(wmLow_ff) && $stable(wmHigh_ff) |=> regRData_ff[7];
  endproperty
  a_wm_zero: assert property (p_wm_zero)
    else $error("watermark flag low with zero watermark");
  property p_bypass;
    mode_ff[2:0] == 3'h0 && $past(mode_ff[2:0]) == 3'h0 && regRead
      && regAddr inside {8'h3a, 8'h3e, 8'h3f} |=> regRData_ff == 8'h00;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass mode holds data");
  property p_irq_a;
    !routeA_ff[3] && !routeA_ff[5] |=> !irqPinA_ff;
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("irq a raised while unrouted");
  property p_irq_b;
    !routeB_ff[3] |=> !irqPinB_ff;
  endproperty
  a_irq_b: assert property (p_irq_b)
    else $error("irq b raised while unrouted");
endmodule // sensor_fifo_checker

bind sensor_sample_fifo sensor_fifo_checker checker_inst
(
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
  .regWData(regWData), .regRead(regRead), .regRData_ff(regRData_ff),
  .irqPinA_ff(irqPinA_ff), .irqPinB_ff(irqPinB_ff)
);

//--- testbench/fifo_host_model.sv
// host model driving the byte-wide register port as the serial host would
// assumes the fifo clock; requests launch 1 ns after a rising edge
`timescale 1ns/100ps
module fifo_host_model
(
  // clock
  input  wire       core_clk,
  // register port
  output reg  [7:0] regAddr,
  output reg        regWrite,
  output reg  [7:0] regWData,
  output reg        regRead,
  input  wire [7:0] regRData_ff
);
  initial
  begin
    regAddr = 8'h00;
    regWData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // one-cycle write; idle lines show the inverse so stale values never match
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    regAddr = a;
    regWData = d;
    regWrite = 1'b1;
    @(posedge core_clk);
    #1;
    regWrite = 1'b0;
    regAddr = ~a;
    regWData = ~d;
  end
  endtask
  // read; trailing edge keeps a pop apart from the next low-byte read
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge core_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d = regRData_ff;
    @(posedge core_clk);
    #1;
  end
  endtask
endmodule // fifo_host_model

//--- testbench/sensor_sample_fifo_test.sv
// self-checking bench for the sensor sample fifo
// assumes the host model owns the register port; sensor side driven here
`timescale 1ns/100ps
module sensor_sample_fifo_test;
  reg         core_clk, rst, comboDataReady, hubDataReady, stepDetect;
  reg  [3:0]  trg;
  reg  [47:0] gyroSet, accelSet, extFirst, extLast, stepTime;
  reg  [15:0] temperature, w;
  wire [7:0]  regAddr, regWData, regRData_ff;
  wire        regWrite, regRead, irqPinA_ff, irqPinB_ff;
  reg  [7:0]  lo, hi;
  integer     n_fail, n_tests, i, k;
  localparam [63:0] OFFS = 64'h0607_0809_0a0d_0e20;
  localparam [47:0] DECI = 48'h0203_0408_1020;

  fifo_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrite(regWrite),
    .regWData(regWData), .regRead(regRead), .regRData_ff(regRData_ff));
  sensor_sample_fifo dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regWData(regWData), .regRead(regRead),
    .regRData_ff(regRData_ff), .comboDataReady(comboDataReady),
    .hubDataReady(hubDataReady), .stepDetect(stepDetect), .functionEvent(trg[0]),
    .tapEvent(trg[1]), .wakeupEvent(trg[2]), .orientationEvent(trg[3]),
    .gyroSet(gyroSet), .accelSet(accelSet), .extSensorFirstSet(extFirst),
    .extSensorLastSet(extLast), .stepTimeSet(stepTime), .temperature(temperature),
    .irqPinA_ff(irqPinA_ff), .irqPinB_ff(irqPinB_ff));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  task chk(input string n, input [15:0] seen, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD %0s expected %h seen %h", n, exp, seen);
    end
  end
  endtask
  task st(input [7:0] a, input [7:0] e);
  begin
    host.rd(a, lo);
    chk($sformatf("reg %h", a), {8'h00, lo}, {8'h00, e});
  end
  endtask
  task rd16;
  begin
    host.rd(8'h3e, lo);
    host.rd(8'h3f, hi);
    w = {hi, lo};
  end
  endtask
  // pacing pulses kept 15 cycles apart, inside the emit window limit
  task pace(input integer s, input integer n);
  begin
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      comboDataReady = (s == 0);
      hubDataReady = (s == 1);
      stepDetect = (s == 2);
      @(posedge core_clk);
      #1;
      {comboDataReady, hubDataReady, stepDetect} = 3'h0;
      repeat (13) @(posedge core_clk);
      #1;
    end
  end
  endtask
  // restart in a mode via bypass, which empties the store first
  task mode(input [7:0] m);
  begin
    host.wr(8'h0a, 8'h00);
    host.wr(8'h0a, m);
  end
  endtask
  task end_sim;
  begin
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // watchdog well beyond the roughly 22k cycles of traffic
  initial
  begin
    #(8 * 60000);
    n_fail = n_fail + 1;
    end_sim;
  end

  initial
  begin
    {core_clk, comboDataReady, hubDataReady, stepDetect, trg} = 8'h00;
    {n_fail, n_tests} = 0;
    gyroSet = 48'h6655_4433_2211;
    accelSet = 48'hccbb_aa99_8877;
    extFirst = 48'h0e0d_0c0b_0a09;
    extLast = 48'h1f1e_1d1c_1b1a;
    stepTime = 48'h2f2e_2d2c_2b2a;
    temperature = 16'h3a39;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    // reset values, then an unmapped offset
    for (i = 0; i < 8; i = i + 1)
      st(OFFS[63-8*i -: 8], 8'h00);
    st(8'h3b, 8'h90);
    // only the selected pacing source stores
    host.wr(8'h08, 8'h01);
    for (k = 0; k < 3; k = k + 1)
    begin
      host.wr(8'h07, k << 3);
      mode(8'h01);
      pace((k + 1) % 3, 1);
      pace((k + 2) % 3, 1);
      st(8'h3a, 8'h00);
      pace(k, 1);
      st(8'h3a, 8'h03);
    end
    // gyro then accel words, watermark 4 routed to pin b
    host.wr(8'h07, 8'h00);
    host.wr(8'h06, 8'h04);
    host.wr(8'h08, 8'h09);
    host.wr(8'h0e, 8'h08);
    host.wr(8'h0d, 8'h20);
    mode(8'h01);
    pace(0, 1);
    st(8'h3a, 8'h06);
    st(8'h3b, 8'h80);
    chk("irqB", irqPinB_ff, 16'h1);
    for (i = 0; i < 6; i = i + 1)
    begin
      rd16;
      chk("word", w, {accelSet, gyroSet} >> (16 * i));
      if (i == 2)
        st(8'h3a, 8'h03);
    end
    chk("irqB", irqPinB_ff, 16'h0);
    st(8'h3b, 8'h10);
    st(8'h3e, 8'h00);
    // set three then the selectable fourth set
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'h09);
    for (k = 0; k < 3; k = k + 1)
    begin
      mode(8'h01 | (k << 5));
      pace(0, 1);
      for (i = 0; i < 6; i = i + 1)
      begin
        rd16;
        if (i == 0)
          chk("set3", w, extFirst[15:0]);
        if (i == 3)
          chk("set4", w, {temperature, stepTime[15:0], extLast[15:0]} >> (16 * k));
      end
    end
    // every decimation factor stores once per window of that many events
    host.wr(8'h09, 8'h00);
    for (k = 0; k < 6; k = k + 1)
    begin
      host.wr(8'h08, (k + 2) << 3);
      mode(8'h01);
      pace(0, DECI[47-8*k -: 8]);
      st(8'h3a, 8'h03);
    end
    // halt bit caps depth at the watermark
    host.wr(8'h08, 8'h01);
    host.wr(8'h09, 8'h40);
    mode(8'h01);
    pace(0, 2);
    st(8'h3a, 8'h04);
    host.wr(8'h09, 8'h00);
    // bypass-to-continuous per trigger source
    for (k = 0; k < 4; k = k + 1)
    begin
      mode(8'h04 | (k << 3));
      pace(0, 1);
      st(8'h3a, 8'h00);
      trg = 4'h1 << k;
      pace(0, 1);
      st(8'h3a, 8'h03);
      trg = 4'h0;
      repeat (4) @(posedge core_clk);
      st(8'h3a, 8'h00);
    end
    // fill in stop mode, then continuous-to-stop around the trigger
    mode(8'h01);
    for (i = 0; i < 1366; i = i + 1)
    begin
      pace(0, 1);
      if (i == 99)
        st(8'h3b, 8'h81);
    end
    st(8'h3b, 8'ha0);
    chk("irqA", irqPinA_ff, 16'h1);
    trg = 4'h1;
    host.wr(8'h0a, 8'h03);
    pace(0, 1);
    st(8'h3b, 8'ha0);
    trg = 4'h0;
    pace(0, 1);
    st(8'h3b, 8'he0);
    // plain continuous keeps overwriting; each sample after the switch drops the oldest words
    host.wr(8'h0a, 8'h06);
    pace(0, 1);
    st(8'h3b, 8'he0);
    rd16;
    rd16;
    chk("cont", w, gyroSet[31:16]);
    host.wr(8'h0a, 8'h00);
    st(8'h3b, 8'h10);
    chk("irqA", irqPinA_ff, 16'h0);
    end_sim;
  end
endmodule // sensor_sample_fifo_test
